// [logic/tft_panel_output.sv]
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,      // System clock.
    input  wire logic             reset_n_in,  // Asynchronous reset.
    input  wire logic [WIDTH-1:0] in_data_in,  // Write word.
    input  wire logic             in_valid_in, // Write request.
    output logic                  in_ready_out, // Space available.
    output logic [WIDTH-1:0]      out_data_out, // Head word.
    output logic                  out_valid_out, // Head valid.
    input  wire logic             out_ready_in  // Pop request.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop, next_in_ready;

    always_comb begin
        push          = in_valid_in && in_ready_out;
        pop           = out_valid_out && out_ready_in;
        next_wr_ptr   = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr   = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count    = (AW+1)'(count + push - pop);
        next_in_ready = next_count < (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            count        <= '0;
            in_ready_out <= 1'b0;
        end else begin
            wr_ptr       <= next_wr_ptr;
            rd_ptr       <= next_rd_ptr;
            count        <= next_count;
            in_ready_out <= next_in_ready;
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    assign out_valid_out = count != '0;
    assign out_data_out  = mem[rd_ptr];

    fifo_bound_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");
endmodule

module tft_panel_output #(
    parameter int PWR_STEP_CYCLES = tft_panel_pkg::PWR_STEP_CYCLES,
    parameter int SHIFT_HALF      = tft_panel_pkg::SHIFT_HALF,
    parameter int FIFO_DEPTH      = tft_panel_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_in,                 // 200 MHz clock.
    input  wire logic        reset_n_in,             // Asynchronous reset.
    input  wire logic [23:0] pixel_in,               // Mixer pixel, red high.
    input  wire logic        pixel_valid_in,         // Mixer pixel valid.
    output logic             pixel_ready_out,        // FIFO has space.
    input  wire logic        panel_enable_in,        // Request panel power.
    input  wire logic        width_24_in,            // 24-bit lines, else 18.
    input  wire logic        two_pixel_in,           // Two pixels per clock.
    input  wire logic [2:0]  resolution_in,          // Resolution code.
    input  wire logic [3:0]  colour_depth_in,        // Panel bits per colour.
    output logic             pixel_shift_clock_out,  // Panel shift clock.
    output logic             hsync_out,              // Horizontal sync.
    output logic             vsync_out,              // Vertical sync.
    output logic             line_data_enable_out,   // Line data enable.
    output logic [23:0]      panel_data_lines_out,   // First pixel lines.
    output logic [23:0]      panel_data_b_out,       // Second pixel lines.
    output logic             panel_supply_enable_out, // Panel VDD enable.
    output logic             backlight_enable_out,   // Backlight enable.
    output logic             crt_disable_out,        // CRT output off.
    output logic             underrun_out            // FIFO ran dry.
);
    typedef tft_panel_pkg::power_type power_type;
    localparam int SW = $clog2(SHIFT_HALF + 1);

    power_type   state, next_state;
    logic [31:0] timer, next_timer;
    logic        signals_on;
    logic [23:0] fifo_data;
    logic        fifo_valid, fifo_pop;

    pixel_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .in_data_in    (pixel_in),
        .in_valid_in   (pixel_valid_in),
        .in_ready_out  (pixel_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    // Backlight goes off before the signals stop, and VDD drops last.
    always_comb begin
        next_state = state;
        next_timer = '0;
        case (state)
            tft_panel_pkg::PWR_OFF: begin
                if (panel_enable_in) next_state = tft_panel_pkg::PWR_VDD_ON;
            end
            tft_panel_pkg::PWR_VDD_ON, tft_panel_pkg::PWR_SIG_ON: begin
                next_timer = timer + 32'h1;
                if (!panel_enable_in) begin
                    next_state = tft_panel_pkg::PWR_BKL_OFF;
                    next_timer = '0;
                end else if (timer >= 32'(PWR_STEP_CYCLES - 1)) begin
                    next_state = (state == tft_panel_pkg::PWR_VDD_ON) ?
                                 tft_panel_pkg::PWR_SIG_ON : tft_panel_pkg::PWR_RUN;
                    next_timer = '0;
                end
            end
            tft_panel_pkg::PWR_RUN: begin
                if (!panel_enable_in) next_state = tft_panel_pkg::PWR_BKL_OFF;
            end
            tft_panel_pkg::PWR_BKL_OFF, tft_panel_pkg::PWR_SIG_OFF: begin
                next_timer = timer + 32'h1;
                if (timer >= 32'(PWR_STEP_CYCLES - 1)) begin
                    next_state = (state == tft_panel_pkg::PWR_BKL_OFF) ?
                                 tft_panel_pkg::PWR_SIG_OFF : tft_panel_pkg::PWR_OFF;
                    next_timer = '0;
                end
            end
            default: next_state = tft_panel_pkg::PWR_OFF;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state                   <= tft_panel_pkg::PWR_OFF;
            timer                   <= '0;
            panel_supply_enable_out <= 1'b0;
            backlight_enable_out    <= 1'b0;
            crt_disable_out         <= 1'b0;
        end else begin
            state                   <= next_state;
            timer                   <= next_timer;
            panel_supply_enable_out <= next_state != tft_panel_pkg::PWR_OFF;
            backlight_enable_out    <= next_state == tft_panel_pkg::PWR_RUN;
            crt_disable_out         <= next_state != tft_panel_pkg::PWR_OFF;
        end
    end

    assign signals_on = state == tft_panel_pkg::PWR_SIG_ON || state == tft_panel_pkg::PWR_RUN
                     || state == tft_panel_pkg::PWR_BKL_OFF;

    function automatic logic [7:0] dither(input logic [7:0] c, input logic [3:0] depth,
                                          input logic [1:0] x, input logic [1:0] y);
        logic [3:0] d, drop, b;
        logic [8:0] sum;
        d    = depth < tft_panel_pkg::DEPTH_MIN ? tft_panel_pkg::DEPTH_MIN :
               depth > tft_panel_pkg::DEPTH_MAX ? tft_panel_pkg::DEPTH_MAX : depth;
        drop = tft_panel_pkg::DEPTH_MAX - d;
        case ({y, x})
            4'h0: b = 4'h0;  4'h1: b = 4'h8;  4'h2: b = 4'h2;  4'h3: b = 4'hA;
            4'h4: b = 4'hC;  4'h5: b = 4'h4;  4'h6: b = 4'hE;  4'h7: b = 4'h6;
            4'h8: b = 4'h3;  4'h9: b = 4'hB;  4'hA: b = 4'h1;  4'hB: b = 4'h9;
            4'hC: b = 4'hF;  4'hD: b = 4'h7;  4'hE: b = 4'hD;  default: b = 4'h5;
        endcase
        sum = {1'b0, c} + {5'h00, b >> (3'h4 - drop[2:0])};
        return (sum[8] ? 8'hFF : sum[7:0]) & (8'hFF << drop);
    endfunction

    function automatic logic [23:0] to_lines(input logic [23:0] p, input logic [3:0] depth,
                                             input logic [1:0] x, input logic [1:0] y,
                                             input logic w24);
        logic [7:0] r, g, b;
        r = dither(p[23:16], w24 ? depth : 4'(depth > 4'h6 ? 4'h6 : depth), x, y);
        g = dither(p[15:8], w24 ? depth : 4'(depth > 4'h6 ? 4'h6 : depth), x, y);
        b = dither(p[7:0], w24 ? depth : 4'(depth > 4'h6 ? 4'h6 : depth), x, y);
        return w24 ? {r, g, b} : {r[7:2], 2'h0, g[7:2], 2'h0, b[7:2], 2'h0};
    endfunction

    logic [SW-1:0] div, next_div;
    logic          next_sclk, fall;
    logic [11:0]   h, v, next_h, next_v, h_act, v_act, h_tot, v_tot;
    logic [1:0]    frame, next_frame, have, next_have;
    logic [23:0]   hold0, hold1, next_hold0, next_hold1, next_data, next_data_b;
    logic          next_hs, next_vs, next_de, next_under, de_now;

    always_comb begin
        case (resolution_in)
            tft_panel_pkg::RES_320:  begin h_act = 12'h140; v_act = 12'h0F0; end
            tft_panel_pkg::RES_640:  begin h_act = 12'h280; v_act = 12'h1E0; end
            tft_panel_pkg::RES_800:  begin h_act = 12'h320; v_act = 12'h258; end
            tft_panel_pkg::RES_1024: begin h_act = 12'h400; v_act = 12'h300; end
            tft_panel_pkg::RES_1280: begin h_act = 12'h500; v_act = 12'h400; end
            default:                 begin h_act = 12'h640; v_act = 12'h4B0; end
        endcase
        if (two_pixel_in) h_act = h_act >> 1;
        h_tot = h_act + tft_panel_pkg::H_FRONT + tft_panel_pkg::H_SYNC + tft_panel_pkg::H_BACK;
        v_tot = v_act + tft_panel_pkg::V_FRONT + tft_panel_pkg::V_SYNC + tft_panel_pkg::V_BACK;
    end

    // Outputs change on the falling shift edge so the panel samples stable data.
    always_comb begin
        next_div    = (div == SW'(SHIFT_HALF - 1)) ? '0 : SW'(div + 1'b1);
        next_sclk   = (div == SW'(SHIFT_HALF - 1)) ? !pixel_shift_clock_out
                                                   : pixel_shift_clock_out;
        fall        = (div == SW'(SHIFT_HALF - 1)) && pixel_shift_clock_out;
        de_now      = h < h_act && v < v_act;
        next_h      = h;
        next_v      = v;
        next_frame  = frame;
        next_hs     = hsync_out;
        next_vs     = vsync_out;
        next_de     = line_data_enable_out;
        next_data   = panel_data_lines_out;
        next_data_b = panel_data_b_out;
        next_have   = have;
        next_hold0  = hold0;
        next_hold1  = hold1;
        next_under  = underrun_out;
        fifo_pop    = signals_on && fifo_valid && !(fall && de_now)
                   && have < (two_pixel_in ? 2'h2 : 2'h1);
        if (fifo_pop) begin
            if (have == 2'h0) next_hold0 = fifo_data;
            else next_hold1 = fifo_data;
            next_have = have + 2'h1;
        end
        if (fall) begin
            next_h  = (h == h_tot - 12'h1) ? 12'h000 : h + 12'h1;
            if (h == h_tot - 12'h1) begin
                next_v = (v == v_tot - 12'h1) ? 12'h000 : v + 12'h1;
                if (v == v_tot - 12'h1) next_frame = frame + 2'h1;
            end
            next_de = de_now;
            next_hs = h >= h_act + tft_panel_pkg::H_FRONT
                   && h < h_act + tft_panel_pkg::H_FRONT + tft_panel_pkg::H_SYNC;
            next_vs = v >= v_act + tft_panel_pkg::V_FRONT
                   && v < v_act + tft_panel_pkg::V_FRONT + tft_panel_pkg::V_SYNC;
            next_data   = tft_panel_pkg::DATA_RESET;
            next_data_b = tft_panel_pkg::DATA_RESET;
            if (de_now) begin
                if (have == (two_pixel_in ? 2'h2 : 2'h1)) begin
                    next_data = to_lines(hold0, colour_depth_in,
                        two_pixel_in ? {h[0], 1'b0} : h[1:0], v[1:0] ^ frame, width_24_in);
                    if (two_pixel_in) next_data_b = to_lines(hold1, colour_depth_in,
                        {h[0], 1'b1}, v[1:0] ^ frame, width_24_in);
                end else begin
                    next_under = 1'b1;
                end
                next_have = 2'h0;
            end
        end
        if (!signals_on) begin
            next_div    = '0;
            next_sclk   = 1'b0;
            next_h      = '0;
            next_v      = '0;
            next_hs     = 1'b0;
            next_vs     = 1'b0;
            next_de     = 1'b0;
            next_data   = tft_panel_pkg::DATA_RESET;
            next_data_b = tft_panel_pkg::DATA_RESET;
            next_under  = 1'b0;
            next_have   = 2'h0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div                   <= '0;
            pixel_shift_clock_out <= 1'b0;
            h                     <= '0;
            v                     <= '0;
            frame                 <= '0;
            hsync_out             <= 1'b0;
            vsync_out             <= 1'b0;
            line_data_enable_out  <= 1'b0;
            panel_data_lines_out  <= tft_panel_pkg::DATA_RESET;
            panel_data_b_out      <= tft_panel_pkg::DATA_RESET;
            have                  <= '0;
            hold0                 <= '0;
            hold1                 <= '0;
            underrun_out          <= 1'b0;
        end else begin
            div                   <= next_div;
            pixel_shift_clock_out <= next_sclk;
            h                     <= next_h;
            v                     <= next_v;
            frame                 <= next_frame;
            hsync_out             <= next_hs;
            vsync_out             <= next_vs;
            line_data_enable_out  <= next_de;
            panel_data_lines_out  <= next_data;
            panel_data_b_out      <= next_data_b;
            have                  <= next_have;
            hold0                 <= next_hold0;
            hold1                 <= next_hold1;
            underrun_out          <= next_under;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    supply_order_a: assert property (backlight_enable_out |-> panel_supply_enable_out)
        else $error("Backlight on without panel supply.");
    vdd_last_a: assert property ($fell(panel_supply_enable_out) |->
        !backlight_enable_out && !line_data_enable_out) else $error("VDD dropped early.");
    blank_hold_a: assert property (!line_data_enable_out |->
        panel_data_lines_out == 24'h000000) else $error("Data moved during blanking.");
    de_align_a: assert property ($changed(line_data_enable_out) && signals_on |->
        $fell(pixel_shift_clock_out)) else $error("Line enable off the shift edge.");
    data_stable_a: assert property ($rose(pixel_shift_clock_out) |->
        $stable(panel_data_lines_out)) else $error("Data changed at rising edge.");
    lsb_unused_a: assert property ($fell(pixel_shift_clock_out) && !$past(width_24_in) |->
        panel_data_lines_out[1:0] == 2'h0 && panel_data_lines_out[9:8] == 2'h0
        && panel_data_lines_out[17:16] == 2'h0) else $error("18-bit low lines driven.");
    crt_excl_a: assert property (line_data_enable_out |-> crt_disable_out)
        else $error("CRT active with panel output.");
    one_pixel_a: assert property ($fell(pixel_shift_clock_out) && !$past(two_pixel_in) |->
        panel_data_b_out == 24'h000000) else $error("Second pixel in one-pixel mode.");
    signals_off_a: assert property (!signals_on |=>
        !line_data_enable_out && !pixel_shift_clock_out) else $error("Panel timing ran while off.");
endmodule

// [logic/tft_panel_pkg.sv]
package tft_panel_pkg;
    localparam int          CLK_HZ          = 200_000_000;
    localparam int          PWR_STEP_MS     = 10;
    localparam int          PWR_STEP_CYCLES = CLK_HZ / 1000 * PWR_STEP_MS;
    localparam int          SHIFT_HALF      = 2;
    localparam int          FIFO_DEPTH      = 16;
    localparam int          PIXEL_BITS      = 24;
    localparam logic [11:0] H_FRONT         = 12'h008;
    localparam logic [11:0] H_SYNC          = 12'h010;
    localparam logic [11:0] H_BACK          = 12'h010;
    localparam logic [11:0] V_FRONT         = 12'h002;
    localparam logic [11:0] V_SYNC          = 12'h002;
    localparam logic [11:0] V_BACK          = 12'h004;
    localparam logic [3:0]  DEPTH_MIN       = 4'h4;
    localparam logic [3:0]  DEPTH_MAX       = 4'h8;
    localparam logic [23:0] DATA_RESET      = 24'h000000;

    typedef enum logic [2:0] {
        RES_320  = 3'h0,
        RES_640  = 3'h1,
        RES_800  = 3'h2,
        RES_1024 = 3'h3,
        RES_1280 = 3'h4,
        RES_1600 = 3'h5
    } res_type;

    typedef enum logic [2:0] {
        PWR_OFF     = 3'h0,
        PWR_VDD_ON  = 3'h1,
        PWR_SIG_ON  = 3'h2,
        PWR_RUN     = 3'h3,
        PWR_BKL_OFF = 3'h4,
        PWR_SIG_OFF = 3'h5
    } power_type;
endpackage

// [testbench/panel_model.sv]
`timescale 1ns/1ps
module panel_model (
    input  wire logic        shift_clock_in, // Panel shift clock.
    input  wire logic        hsync_in,       // Horizontal sync.
    input  wire logic        vsync_in,       // Vertical sync.
    input  wire logic        lde_in,         // Line data enable.
    input  wire logic [23:0] data_a_in,      // First pixel lines.
    input  wire logic [23:0] data_b_in,      // Second pixel lines.
    output logic      [11:0] line_len_out,   // Enabled shift clocks in the last line.
    output logic      [15:0] lines_out,      // Lines seen so far.
    output logic      [23:0] last_a_out,     // Last first pixel taken.
    output logic      [23:0] last_b_out,     // Last second pixel taken.
    output logic             blank_bad_out,  // Data moved in blanking.
    output logic             sync_bad_out    // Sync inside active area.
);
    logic [11:0] count;

    initial begin
        count = 12'h000;
        line_len_out = 12'h000;
        lines_out = 16'h0000;
        last_a_out = 24'h000000;
        last_b_out = 24'h000000;
        blank_bad_out = 1'b0;
        sync_bad_out = 1'b0;
    end

    // The panel only looks at its lines on the rising shift edge, like a real one.
    always @(posedge shift_clock_in) begin
        if (lde_in === 1'b1) begin
            count <= count + 12'h001;
            last_a_out <= data_a_in;
            last_b_out <= data_b_in;
            if (hsync_in !== 1'b0 || vsync_in !== 1'b0) begin
                sync_bad_out <= 1'b1;
            end
        end else begin
            if (data_a_in !== 24'h000000 || data_b_in !== 24'h000000) begin
                blank_bad_out <= 1'b1;
            end
            if (count != 12'h000) begin
                line_len_out <= count;
                lines_out <= lines_out + 16'h0001;
                count <= 12'h000;
            end
        end
    end
endmodule

// [testbench/tft_panel_output_bench.sv]
`timescale 1ns/1ps
module tft_panel_pixel_output_bench;
    localparam int STEP = 20;
    // PIX_A has zero low nibbles so that no dither offset can carry into a kept bit.
    localparam logic [23:0] PIX_A = 24'hA0C030;
    localparam logic [23:0] PIX_B = 24'h18E4F0;

    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [23:0] pixel_in = PIX_A;
    logic        pixel_valid_in = 1'b0;
    logic        panel_enable_in = 1'b0;
    logic        width_24_in = 1'b1;
    logic        two_pixel_in = 1'b0;
    logic [2:0]  resolution_in = 3'h0;
    logic [3:0]  colour_depth_in = 4'h8;
    logic        ready, shift_clk, hsync, vsync, line_data_enable, supply, backlight, crt_off, underrun;
    logic [23:0] data_a, data_b, last_a, last_b, pat_a, pat_b;
    logic [11:0] line_len;
    logic [15:0] lines;
    logic        blank_bad, sync_bad, sel;
    int          errors, cmp_count, accepted;

    always #2.5 clk_in = ~clk_in;

    tft_panel_output #(.PWR_STEP_CYCLES(STEP), .SHIFT_HALF(2), .FIFO_DEPTH(16)) DUT (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .pixel_in(pixel_in),
        .pixel_valid_in(pixel_valid_in), .pixel_ready_out(ready),
        .panel_enable_in(panel_enable_in), .width_24_in(width_24_in),
        .two_pixel_in(two_pixel_in), .resolution_in(resolution_in),
        .colour_depth_in(colour_depth_in), .pixel_shift_clock_out(shift_clk),
        .hsync_out(hsync), .vsync_out(vsync), .line_data_enable_out(line_data_enable),
        .panel_data_lines_out(data_a), .panel_data_b_out(data_b),
        .panel_supply_enable_out(supply), .backlight_enable_out(backlight),
        .crt_disable_out(crt_off), .underrun_out(underrun));

    panel_model panel (
        .shift_clock_in(shift_clk), .hsync_in(hsync), .vsync_in(vsync), .lde_in(line_data_enable),
        .data_a_in(data_a), .data_b_in(data_b), .line_len_out(line_len),
        .lines_out(lines), .last_a_out(last_a), .last_b_out(last_b),
        .blank_bad_out(blank_bad), .sync_bad_out(sync_bad));

    // The mixer holds a refused word and only moves on once it was taken.
    always @(posedge clk_in) begin
        if (pixel_valid_in && ready) begin
            accepted <= accepted + 1;
            pixel_in <= sel ? pat_a : pat_b;
            sel <= ~sel;
        end
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wait_lines(input int n);
        int start;
        int k;
        start = int'(lines);
        k = 0;
        while (int'(lines) - start < n && k < 40000) begin
            @(posedge clk_in);
            k++;
        end
        check(24'(k < 40000), 24'h000001);
    endtask

    task automatic fill_fifo();
        int k;
        k = 0;
        @(posedge clk_in);
        pixel_valid_in <= 1'b1;
        while (ready !== 1'b0 && k < 40) begin
            tick(1);
            k++;
        end
        tick(3);
        check(24'(accepted), 24'h000010);
        check(24'(ready), 24'h000000);
    endtask

    task automatic power_up();
        @(posedge clk_in);
        panel_enable_in <= 1'b1;
        tick(1);
        check({supply, crt_off, backlight}, 24'h000006);
        tick(2 * STEP - 1);
        check(24'(backlight), 24'h000000);
        tick(1);
        check(24'(backlight), 24'h000001);
    endtask

    task automatic power_down();
        @(posedge clk_in);
        panel_enable_in <= 1'b0;
        tick(1);
        check({supply, backlight}, 24'h000002);
        tick(STEP);
        check(24'(supply), 24'h000001);
        tick(STEP + 2);
        check({supply, crt_off, shift_clk, underrun}, 24'h000000);
    endtask

    task automatic mapping_and_dither();
        wait_lines(2);
        check(last_a, PIX_A);
        check(last_b, 24'h000000);
        check(24'(line_len), 24'h000140);
        width_24_in <= 1'b0;
        wait_lines(2);
        check(last_a, PIX_A & 24'hFCFCFC);
        width_24_in <= 1'b1;
        colour_depth_in <= 4'h4;
        wait_lines(2);
        check(last_a, PIX_A & 24'hF0F0F0);
        colour_depth_in <= 4'h8;
        wait_lines(2);
        check(last_a, PIX_A);
    endtask

    task automatic resolutions();
        logic [11:0] widths [6];
        widths = '{12'h140, 12'h280, 12'h320, 12'h400, 12'h500, 12'h640};
        for (int r = 1; r < 6; r++) begin
            resolution_in <= 3'(r);
            wait_lines(2);
            check(24'(line_len), 24'(widths[r]));
        end
        resolution_in <= 3'h0;
        wait_lines(2);
    endtask

    task automatic starve();
        int k;
        k = 0;
        pixel_valid_in <= 1'b0;
        while (underrun !== 1'b1 && k < 20000) begin
            tick(1);
            k++;
        end
        check(24'(underrun), 24'h000001);
    endtask

    task automatic two_pixels();
        @(posedge clk_in);
        two_pixel_in <= 1'b1;
        pat_a <= PIX_A;
        pat_b <= PIX_B;
        pixel_in <= PIX_A;
        sel <= 1'b0;
        pixel_valid_in <= 1'b1;
        power_up();
        wait_lines(2);
        check(24'(line_len), 24'h0000A0);
        check(last_a, PIX_A);
        check(last_b, PIX_B);
    endtask

    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #480000;
        errors++;
        wrap_up();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        accepted = 0;
        sel = 1'b0;
        pat_a = PIX_A;
        pat_b = PIX_A;
        tick(4);
        check({ready, supply, crt_off, backlight, shift_clk}, 24'h000000);
        check(data_a, 24'h000000);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        tick(2);
        check({ready, crt_off}, 24'h000002);
        fill_fifo();
        power_up();
        mapping_and_dither();
        resolutions();
        check({blank_bad, sync_bad}, 24'h000000);
        starve();
        power_down();
        two_pixels();
        check({blank_bad, sync_bad}, 24'h000000);
        wrap_up();
    end
endmodule
